//--- include/gpc_pkg.sv
/*
 * Types for the general-purpose port.
 * Assumes gpc_regs.svh on the include path.
 */
`include "gpc_regs.svh"

package gpc_pkg;

    // Drive configuration of one pin
    typedef enum logic [2:0] {
        DM_OFF      = `GPC_DM_OFF,
        DM_INPUT    = `GPC_DM_INPUT,
        DM_STRONG   = `GPC_DM_STRONG,
        DM_RES_UP   = `GPC_DM_RES_UP,
        DM_RES_DN   = `GPC_DM_RES_DN,
        DM_OPEN_DR  = `GPC_DM_OPEN_DR,
        DM_OPEN_SRC = `GPC_DM_OPEN_SRC,
        DM_WEAK     = `GPC_DM_WEAK
    } gpc_mode_t;

    // Hold controller states, one-hot
    typedef enum logic [1:0] {
        ST_RUN  = 2'h1,
        ST_HELD = 2'h2
    } gpc_state_t;

endpackage : gpc_pkg

//--- include/gpc_regs.svh
/*
 * Constants for the general-purpose port: drive mode codes, edge
 * codes, matrix sources and pin counts per package.
 * Assumes inclusion by bare name from package and design files.
 */
`ifndef GPC_REGS_SVH
`define GPC_REGS_SVH

// Drive mode codes, three bits per pin
`define GPC_DM_OFF      3'h0
`define GPC_DM_INPUT    3'h1
`define GPC_DM_STRONG   3'h2
`define GPC_DM_RES_UP   3'h3
`define GPC_DM_RES_DN   3'h4
`define GPC_DM_OPEN_DR  3'h5
`define GPC_DM_OPEN_SRC 3'h6
`define GPC_DM_WEAK     3'h7
`define GPC_DM_W        3

// Interrupt edge codes, two bits per pin
`define GPC_EDGE_NONE   2'h0
`define GPC_EDGE_RISE   2'h1
`define GPC_EDGE_FALL   2'h2
`define GPC_EDGE_BOTH   2'h3
`define GPC_EDGE_W      2

// Matrix source zero is the output-data register
`define GPC_SRC_DATA    2'h0
`define GPC_SRC_W       2

// Pin counts per package
`define GPC_PINS_LARGE  8
`define GPC_PINS_SMALL  5

`endif

//--- rtl/gpc_pad_decode.sv
/*
 * Decodes one pin's drive mode and data into driver controls.
 * Assumes a pad with separate driver, pull and weak-keeper controls.
 */
`timescale 1ns/100ps

module gpc_pad_decode (
    // Configuration
    input  wire gpc_pkg::gpc_mode_t mode_i,
    input  wire logic               data_i,
    input  wire logic               out_dis_i,
    // Driver controls
    output logic                    drv_o,
    output logic                    lvl_o,
    output logic                    pu_o,
    output logic                    pd_o,
    output logic                    weak_o,
    output logic                    ie_o
);

    logic drv;

    // Mode table: driven level, pulls and input buffer
    always_comb begin
        drv    = 1'b0;
        lvl_o  = data_i;
        pu_o   = 1'b0;
        pd_o   = 1'b0;
        weak_o = 1'b0;
        ie_o   = (mode_i != gpc_pkg::DM_OFF);
        unique case (mode_i)
            gpc_pkg::DM_OFF, gpc_pkg::DM_INPUT: begin
                drv = 1'b0;
            end
            gpc_pkg::DM_STRONG: begin
                drv = 1'b1;
            end
            gpc_pkg::DM_RES_UP: begin
                drv  = ~data_i;
                pu_o = data_i;
            end
            gpc_pkg::DM_RES_DN: begin
                drv  = data_i;
                pd_o = ~data_i;
            end
            gpc_pkg::DM_OPEN_DR: begin
                drv = ~data_i;
            end
            gpc_pkg::DM_OPEN_SRC: begin
                drv = data_i;
            end
            gpc_pkg::DM_WEAK: begin
                weak_o = 1'b1;
                pu_o   = data_i;
                pd_o   = ~data_i;
            end
        endcase
    end

    // Output disable cuts the driver only
    assign drv_o = drv & ~out_dis_i;

endmodule : gpc_pad_decode

//--- rtl/gpc_port.sv
/*
 * General-purpose I/O port: drive modes, output data, pin state,
 * pin interrupts, signal matrix and sleep hold.
 * Assumes configuration ports held by software, clk_i running at the
 * low-frequency rate in sleep, and pad_in_i asynchronous.
 */
// Notes on behaviour
// [R1] Eight drive modes per pin
// [R2] CMOS or LVTTL input threshold per pin
// [R3] Input and output disables are independent
// [R4] Hold freezes pins at last driven state
// [R5] Per-pin slew-rate select
// [R6] Reset forces every pin disabled
// [R7] Output-data register and pin-state register
// [R8] Pin interrupt only when enabled
// [R9] One interrupt request per port
// [R10] Sleep either holds pins or keeps running
// [R11] Reset wake leaves pins high impedance
// [R12] Interrupt wake keeps held state until software
// [R13] Matrix selects data or peripheral per pin
// [R14] Fixed-function pins bypass the matrix
// [R15] Eight pins large package, five small
// [R16] Software configures, port applies settings
// [R17] Hold and wake detection need no fast clock
// [R18] Pending flag set by event, write-one clears
// [R19] Hold captures current drive when asserted
`timescale 1ns/100ps
`include "gpc_regs.svh"

module gpc_port #(
    parameter int           N_PINS     = `GPC_PINS_LARGE,
    parameter bit           LARGE_PKG  = 1'b1,
    parameter logic [7:0]   FIXED_MASK = 8'h00,
    parameter int           N_SRC      = 3
) (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    // Pin configuration
    input  wire logic [3*N_PINS-1:0]      mode_i,
    input  wire logic [N_PINS-1:0]        thr_sel_i,
    input  wire logic [N_PINS-1:0]        in_dis_i,
    input  wire logic [N_PINS-1:0]        out_dis_i,
    input  wire logic [N_PINS-1:0]        slew_i,
    input  wire logic [2*N_PINS-1:0]      sel_i,
    // Output-data register
    input  wire logic                     dout_wr_i,
    input  wire logic [N_PINS-1:0]        dout_wdata_i,
    output logic      [N_PINS-1:0]        dout_o,
    output logic      [N_PINS-1:0]        pin_state_o,
    // Interrupts
    input  wire logic [N_PINS-1:0]        int_en_i,
    input  wire logic [2*N_PINS-1:0]      int_edge_i,
    input  wire logic [N_PINS-1:0]        int_clr_i,
    output logic      [N_PINS-1:0]        int_pend_o,
    output logic                          irq_o,
    // Peripheral sources
    input  wire logic [N_SRC*N_PINS-1:0]  per_out_i,
    input  wire logic [N_SRC*N_PINS-1:0]  per_oe_i,
    // Sleep control
    input  wire logic                     hold_i,
    input  wire logic                     sleep_i,
    input  wire logic                     retain_i,
    output logic                          held_o,
    // Pads
    input  wire logic [N_PINS-1:0]        pad_in_i,
    output logic      [N_PINS-1:0]        pad_out_o,
    output logic      [N_PINS-1:0]        pad_oe_n_o,
    output logic      [N_PINS-1:0]        pad_pu_o,
    output logic      [N_PINS-1:0]        pad_pd_o,
    output logic      [N_PINS-1:0]        pad_weak_o,
    output logic      [N_PINS-1:0]        pad_slew_o,
    output logic      [N_PINS-1:0]        pad_thr_o,
    output logic      [N_PINS-1:0]        pad_ie_o
);

    localparam int N_ACT = LARGE_PKG ? `GPC_PINS_LARGE : `GPC_PINS_SMALL;

    gpc_pkg::gpc_state_t state_q;
    gpc_pkg::gpc_state_t state_d;

    logic [N_PINS-1:0] act_mask;
    logic [N_PINS-1:0] pin_sync;
    logic [N_PINS-1:0] pin_prev_q;
    logic [N_PINS-1:0] rise;
    logic [N_PINS-1:0] fall;
    logic [N_PINS-1:0] hit;
    logic [N_PINS-1:0] pend_d;
    logic [N_PINS-1:0] out_d;
    logic [N_PINS-1:0] oe_n_d;
    logic [N_PINS-1:0] pu_d;
    logic [N_PINS-1:0] pd_d;
    logic [N_PINS-1:0] weak_d;
    logic [N_PINS-1:0] ie_d;
    logic              run;
    logic              hold_req;

    // Pin level synchroniser
    gpc_sync #(
        .WIDTH   (N_PINS)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (pad_in_i),
        .sync_o  (pin_sync)
    );

    // Hold request: explicit hold or retaining sleep
    assign hold_req = hold_i | (sleep_i & retain_i); // [R10]
    assign run      = (state_q == gpc_pkg::ST_RUN);

    // Hold controller next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            gpc_pkg::ST_RUN: begin
                if (hold_req) begin
                    state_d = gpc_pkg::ST_HELD; // [R19]
                end
            end
            gpc_pkg::ST_HELD: begin
                // Released once hold_req drops: hold_i low and no retaining sleep
                if (!hold_req) begin
                    state_d = gpc_pkg::ST_RUN; // [R12]
                end
            end
            default: begin
                state_d = gpc_pkg::ST_RUN;
            end
        endcase
    end

    // Hold state; reset always returns to running, pins off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= gpc_pkg::ST_RUN; // [R11]
        end else begin
            state_q <= state_d;
        end
    end

    // Per-pin matrix, drive decode and edge detection
    genvar gi;
    generate
        for (gi = 0; gi < N_PINS; gi++) begin : g_pin
            logic [`GPC_SRC_W-1:0]  sel;
            logic [`GPC_EDGE_W-1:0] edg;
            logic                   src_dat;
            logic                   src_oe;
            logic                   drv;
            logic                   ie;
            logic                   lvl;
            gpc_pkg::gpc_mode_t     mode;

            // Pins beyond the package count stay disabled
            assign act_mask[gi] = (gi < N_ACT); // [R15]
            assign mode = act_mask[gi]
                ? gpc_pkg::gpc_mode_t'(mode_i[`GPC_DM_W*gi +: `GPC_DM_W])
                : gpc_pkg::DM_OFF; // [R16]
            assign sel = FIXED_MASK[gi]
                ? `GPC_SRC_W'(1) // [R14]
                : sel_i[`GPC_SRC_W*gi +: `GPC_SRC_W];

            // Source zero is the data register
            always_comb begin
                src_dat = dout_o[gi];
                src_oe  = 1'b1;
                if (sel != `GPC_SRC_DATA) begin
                    src_dat = per_out_i[N_PINS*(int'(sel)-1) + gi]; // [R13]
                    src_oe  = per_oe_i[N_PINS*(int'(sel)-1) + gi];
                end
            end

            // Eight drive configurations
            gpc_pad_decode u_dec (
                .mode_i    (mode), // [R1]
                .data_i    (src_dat),
                .out_dis_i (out_dis_i[gi] | ~src_oe),
                .drv_o     (drv),
                .lvl_o     (lvl),
                .pu_o      (pu_d[gi]),
                .pd_o      (pd_d[gi]),
                .weak_o    (weak_d[gi]),
                .ie_o      (ie)
            );

            // Input disable touches only the input buffer
            assign ie_d[gi]   = ie & ~in_dis_i[gi]; // [R3]
            assign oe_n_d[gi] = ~drv; // [R3]
            assign out_d[gi]  = lvl;

            // Edge qualification per pin
            assign edg      = int_edge_i[`GPC_EDGE_W*gi +: `GPC_EDGE_W];
            assign rise[gi] = pin_sync[gi] & ~pin_prev_q[gi];
            assign fall[gi] = ~pin_sync[gi] & pin_prev_q[gi];
            assign hit[gi]  = act_mask[gi] & int_en_i[gi] & ( // [R8]
                ((edg == `GPC_EDGE_RISE) & rise[gi]) |
                ((edg == `GPC_EDGE_FALL) & fall[gi]) |
                ((edg == `GPC_EDGE_BOTH) & (rise[gi] | fall[gi])));
        end
    endgenerate

    // Output-data register written by software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dout_o <= '0;
        end else if (dout_wr_i) begin
            dout_o <= dout_wdata_i; // [R7]
        end
    end

    // Pin-state register and edge history
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_prev_q  <= '0;
            pin_state_o <= '0;
        end else begin
            pin_prev_q  <= pin_sync;
            pin_state_o <= pin_sync & pad_ie_o; // [R7]
        end
    end

    // Pending flags: set wins over write-one clear
    assign pend_d = (int_pend_o & ~int_clr_i) | hit; // [R18]

    // Pending flags and combined port request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_pend_o <= '0;
            irq_o      <= 1'b0;
        end else begin
            int_pend_o <= pend_d;
            irq_o      <= |pend_d; // [R9]
        end
    end

    // Pad controls; frozen while held, all off in reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pad_out_o  <= '0; // [R6]
            pad_oe_n_o <= '1;
            pad_pu_o   <= '0;
            pad_pd_o   <= '0;
            pad_weak_o <= '0;
            pad_ie_o   <= '0;
        end else if (run) begin
            pad_out_o  <= out_d; // [R16]
            pad_oe_n_o <= oe_n_d;
            pad_pu_o   <= pu_d;
            pad_pd_o   <= pd_d;
            pad_weak_o <= weak_d;
            pad_ie_o   <= ie_d;
        end
        // Held flops need no edge to keep their level
        // [R4] [R17]
    end

    // Slew and threshold selects follow the hold too
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pad_slew_o <= '0;
            pad_thr_o  <= '0;
        end else if (run) begin
            pad_slew_o <= slew_i & act_mask; // [R5]
            pad_thr_o  <= thr_sel_i & act_mask; // [R2]
        end
    end

    // Hold status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            held_o <= 1'b0;
        end else begin
            held_o <= (state_d == gpc_pkg::ST_HELD);
        end
    end

    // Pads all released one cycle into and after reset
    reset_off_a: assert property ( // [R6]
        @(posedge clk_i) $past(rst_i) |->
            (pad_oe_n_o == '1) && (pad_pu_o == '0) &&
            (pad_pd_o == '0) && (pad_ie_o == '0))
        else $error("pads not disabled after reset");

    // Held pins keep their drive unchanged
    hold_freeze_a: assert property ( // [R4]
        @(posedge clk_i) disable iff (rst_i)
        (!run && $past(!run)) |->
            $stable(pad_out_o) && $stable(pad_oe_n_o) &&
            $stable(pad_pu_o) && $stable(pad_pd_o))
        else $error("held pad state changed");

    // Entering hold keeps the last running drive
    hold_capture_a: assert property ( // [R19]
        @(posedge clk_i) disable iff (rst_i)
        (!rst_i && run && hold_req) |=> ##1
            (pad_oe_n_o == $past(pad_oe_n_o, 1)) && held_o)
        else $error("hold did not capture drive");

    // Qualified events raise their pending flag
    int_set_a: assert property ( // [R18]
        @(posedge clk_i) disable iff (rst_i)
        (hit != '0) |=> ((int_pend_o & $past(hit)) == $past(hit)))
        else $error("pin event lost");

    // No flag rises on a disabled pin
    int_gate_a: assert property ( // [R8]
        @(posedge clk_i) disable iff (rst_i)
        ##1 ((int_pend_o & ~$past(int_pend_o) & ~$past(int_en_i)) == '0))
        else $error("flag set without enable");

    // Write-one clear with no new event empties flags
    int_clear_a: assert property ( // [R18]
        @(posedge clk_i) disable iff (rst_i)
        (int_clr_i == '1 && hit == '0) |=> (int_pend_o == '0) ##1 !irq_o
            or (int_pend_o == '0) ##1 (irq_o == (|int_pend_o)))
        else $error("clear failed");

    // Port request mirrors any pending flag
    irq_merge_a: assert property ( // [R9]
        @(posedge clk_i) disable iff (rst_i)
        irq_o == (|int_pend_o))
        else $error("port request mismatch");

    // Input disable leaves the input buffer off
    in_dis_a: assert property ( // [R3]
        @(posedge clk_i) disable iff (rst_i)
        run |=> ((pad_ie_o & $past(in_dis_i)) == '0))
        else $error("input enabled while disabled");

    // Output disable leaves the driver off
    out_dis_a: assert property ( // [R3]
        @(posedge clk_i) disable iff (rst_i)
        run |=> ((~pad_oe_n_o & $past(out_dis_i)) == '0))
        else $error("driver on while disabled");

    // Data register takes the written word
    dout_write_a: assert property ( // [R7]
        @(posedge clk_i) disable iff (rst_i)
        dout_wr_i |=> (dout_o == $past(dout_wdata_i)))
        else $error("data register not written");

    // A strong-mode write reaches the pad in two cycles
    data_path_a: assert property ( // [R16]
        @(posedge clk_i) disable iff (rst_i)
        (dout_wr_i && run && !hold_req && mode_i[2:0] == `GPC_DM_STRONG
            && sel_i[1:0] == `GPC_SRC_DATA && !out_dis_i[0]
            && !FIXED_MASK[0]) ##1 (run && !hold_req
            && $stable(mode_i) && $stable(out_dis_i) && $stable(sel_i))
        |=> (pad_out_o[0] == $past(dout_wdata_i[0], 2)))
        else $error("data not driven on pin");

endmodule : gpc_port

//--- rtl/gpc_sync.sv
/*
 * Two-stage synchroniser for a vector of pin levels.
 * Assumes inputs asynchronous to clk_i; only stage two is read.
 */
`timescale 1ns/100ps

module gpc_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Levels
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;

    // Two flops, first read only by second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule : gpc_sync

//--- testbench/gpc_board.sv
/*
 * Board model for the port pins: resolves each pin level from the
 * device drivers, the pulls and an optional external source.
 * Assumes the external source is only enabled where the device does
 * not drive; an undriven, unpulled pin shows a level that toggles.
 */
`timescale 1ns/100ps

module gpc_board #(
    parameter int N = 8
) (
    // Clock
    input  wire logic         clk_i,
    // Device pad controls
    input  wire logic [N-1:0] pad_out_i,
    input  wire logic [N-1:0] pad_oe_n_i,
    input  wire logic [N-1:0] pad_pu_i,
    input  wire logic [N-1:0] pad_pd_i,
    input  wire logic [N-1:0] pad_weak_i,
    // External source
    input  wire logic [N-1:0] ext_lvl_i,
    input  wire logic [N-1:0] ext_en_i,
    // Resolved level
    output logic      [N-1:0] pad_in_o
);
    logic [N-1:0] float_q = '0;

    // Floating pins never settle on one value
    always_ff @(posedge clk_i) begin
        float_q <= ~pad_in_o;
    end

    // Device driver wins, then external source, then pulls
    always_comb begin
        for (int i = 0; i < N; i++) begin
            if (!pad_oe_n_i[i]) pad_in_o[i] = pad_out_i[i];
            else if (ext_en_i[i]) pad_in_o[i] = ext_lvl_i[i];
            else if (pad_pu_i[i]) pad_in_o[i] = 1'b1;
            else if (pad_pd_i[i]) pad_in_o[i] = 1'b0;
            else if (pad_weak_i[i]) pad_in_o[i] = pad_out_i[i];
            else pad_in_o[i] = float_q[i];
        end
    end
endmodule : gpc_board

//--- testbench/gpc_port_test.sv
/*
 * Self-checking bench for the port: drive modes, disables, data and
 * pin state, matrix, interrupts, hold and sleep, reset.
 * Assumes gpc_regs.svh on the include path and default parameters.
 */
`timescale 1ns/100ps
`include "gpc_regs.svh"

module gpc_port_test;
    typedef struct {int sel; logic [7:0] m; logic [7:0] e; int due;} gpc_note_t;
    logic clk_i, rst_i, dout_wr_i, hold_i, sleep_i, retain_i;
    logic [23:0] mode_i, per_out_i, per_oe_i;
    logic [15:0] sel_i, int_edge_i, lfsr_q;
    logic [7:0]  thr_sel_i, in_dis_i, out_dis_i, slew_i, dout_wdata_i, int_en_i, int_clr_i;
    logic [7:0]  ext_lvl, ext_en, pad_in, dout_o, pin_state_o, int_pend_o, pad_out_o;
    logic [7:0]  pad_oe_n_o, pad_pu_o, pad_pd_o, pad_weak_o, pad_slew_o, pad_thr_o, pad_ie_o;
    logic        irq_o, held_o;
    gpc_note_t   notes[$];
    int          cyc, fails, total_checks;

    gpc_port u_gpc_port (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode_i), .thr_sel_i(thr_sel_i),
        .in_dis_i(in_dis_i), .out_dis_i(out_dis_i), .slew_i(slew_i), .sel_i(sel_i),
        .dout_wr_i(dout_wr_i), .dout_wdata_i(dout_wdata_i), .dout_o(dout_o),
        .pin_state_o(pin_state_o), .int_en_i(int_en_i), .int_edge_i(int_edge_i),
        .int_clr_i(int_clr_i), .int_pend_o(int_pend_o), .irq_o(irq_o), .per_out_i(per_out_i),
        .per_oe_i(per_oe_i), .hold_i(hold_i), .sleep_i(sleep_i), .retain_i(retain_i),
        .held_o(held_o), .pad_in_i(pad_in), .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o),
        .pad_pu_o(pad_pu_o), .pad_pd_o(pad_pd_o), .pad_weak_o(pad_weak_o),
        .pad_slew_o(pad_slew_o), .pad_thr_o(pad_thr_o), .pad_ie_o(pad_ie_o));

    gpc_board u_gpc_board (.clk_i(clk_i), .pad_out_i(pad_out_o), .pad_oe_n_i(pad_oe_n_o),
        .pad_pu_i(pad_pu_o), .pad_pd_i(pad_pd_o), .pad_weak_i(pad_weak_o),
        .ext_lvl_i(ext_lvl), .ext_en_i(ext_en), .pad_in_o(pad_in));

    // Clock at 10 MHz
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    // Expected output enable (low = driving) for a mode and data bit
    function automatic logic exp_oen(input logic [2:0] m, input logic d);
        case (m)
            `GPC_DM_STRONG:   return 1'b0;
            `GPC_DM_RES_UP:   return d;
            `GPC_DM_RES_DN:   return !d;
            `GPC_DM_OPEN_DR:  return d;
            `GPC_DM_OPEN_SRC: return !d;
            default:          return 1'b1;
        endcase
    endfunction : exp_oen

    function automatic logic [7:0] obs(input int s);
        case (s)
            0: return pad_oe_n_o;
            1: return pad_out_o;
            2: return pad_ie_o;
            3: return pad_slew_o;
            4: return pad_thr_o;
            5: return dout_o;
            6: return pin_state_o;
            7: return int_pend_o;
            8: return {7'h00, irq_o};
            9: return {7'h00, held_o};
            11: return pad_weak_o;
            default: return {pad_pu_o[3:0], pad_pd_o[3:0]};
        endcase
    endfunction : obs

    task automatic check(input int s, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] output %0d at cycle %0d expected %h seen %h", s, cyc, exp, seen);
        end
    endtask : check

    // Note an expected value, due lat cycles after the next edge
    task automatic note(input int s, input logic [7:0] m, input logic [7:0] e, input int lat);
        notes.push_back('{s, m, e, cyc + 1 + lat});
    endtask : note

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    // Watcher: compares every due note with what the outputs show
    always @(negedge clk_i) begin
        cyc = cyc + 1;
        if (cyc > 2000) begin
            fails++;
            end_of_test();
        end
        for (int i = notes.size() - 1; i >= 0; i--) begin
            if (notes[i].due == cyc) begin
                check(notes[i].sel, obs(notes[i].sel) & notes[i].m, notes[i].e & notes[i].m);
                notes.delete(i);
            end
        end
    end

    initial begin
        rst_i = 1'b1; mode_i = {8{`GPC_DM_STRONG}}; sel_i = '0; per_out_i = '0; per_oe_i = '0;
        thr_sel_i = '1; in_dis_i = '0; out_dis_i = '0; slew_i = '1; dout_wr_i = 1'b0;
        dout_wdata_i = '1; int_en_i = '0; int_edge_i = '0; int_clr_i = '0; hold_i = 1'b0;
        sleep_i = 1'b0; retain_i = 1'b0; ext_lvl = '0; ext_en = '1; lfsr_q = 16'h99E0;
        cyc = 0; fails = 0; total_checks = 0;
        // Reset overrides a strong configuration
        @(posedge clk_i);
        note(0, 8'hFF, 8'hFF, 1);
        note(10, 8'hFF, 8'h00, 1);
        note(8, 8'h01, 8'h00, 1);
        tick(3);
        rst_i <= 1'b0;
        tick(2);
        // Every drive mode with both data levels on pin 0
        for (int m = 0; m < 8; m++) begin
            for (int d = 0; d < 2; d++) begin
                @(posedge clk_i);
                mode_i[2:0] <= 3'(m);
                dout_wr_i <= 1'b1;
                dout_wdata_i <= {7'h00, 1'(d)};
                note(0, 8'h01, {7'h00, exp_oen(3'(m), 1'(d))}, 2);
                note(2, 8'h01, {7'h00, m != 0}, 2);
                if (!exp_oen(3'(m), 1'(d))) note(1, 8'h01, {7'h00, 1'(d)}, 2);
                note(10, 8'h10, {3'h0, d && (m == 3 || m == 7), 4'h0}, 2);
                note(10, 8'h01, {7'h00, !d && (m == 4 || m == 7)}, 2);
                note(11, 8'h01, {7'h00, m == 7}, 2);
                @(posedge clk_i);
                dout_wr_i <= 1'b0;
                tick(2);
            end
        end
        // Output and input disables act alone
        @(posedge clk_i);
        mode_i[2:0] <= `GPC_DM_STRONG;
        out_dis_i <= 8'h01;
        note(0, 8'h01, 8'h01, 1);
        note(2, 8'h01, 8'h01, 1);
        tick(2);
        out_dis_i <= 8'h00;
        in_dis_i <= 8'h01;
        note(0, 8'h01, 8'h00, 1);
        note(2, 8'h01, 8'h00, 1);
        tick(2);
        in_dis_i <= 8'h00;
        // Random data, slew and threshold, then routing from each source
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            lfsr_q = lfsr_next(lfsr_q);
            dout_wr_i <= 1'b1;
            dout_wdata_i <= lfsr_q[7:0];
            slew_i <= lfsr_q[15:8];
            thr_sel_i <= ~lfsr_q[7:0];
            note(5, 8'hFF, lfsr_q[7:0], 1);
            note(1, 8'hFF, lfsr_q[7:0], 2);
            note(6, 8'hFF, lfsr_q[7:0], 5);
            note(3, 8'hFF, lfsr_q[15:8], 1);
            note(4, 8'hFF, ~lfsr_q[7:0], 1);
            @(posedge clk_i);
            dout_wr_i <= 1'b0;
            tick(5);
            lfsr_q = lfsr_next(lfsr_q);
            // Only the selected source carries data and enable
            sel_i <= {8{2'(1 + k % 3)}};
            per_out_i <= 24'(lfsr_q[7:0]) << (8 * (k % 3));
            per_oe_i <= 24'(lfsr_q[15:8]) << (8 * (k % 3));
            note(0, 8'hFF, ~lfsr_q[15:8], 1);
            note(1, lfsr_q[15:8], lfsr_q[7:0], 1);
            tick(2);
            sel_i <= '0;
            tick(2);
        end
        // Pin 1 edges for each code, last pass with interrupt disabled
        mode_i <= {8{`GPC_DM_INPUT}};
        tick(5);
        int_clr_i <= '1;
        @(posedge clk_i);
        int_clr_i <= '0;
        for (int k = 0; k < 5; k++) begin
            int_en_i <= {6'h00, k < 4, 1'b0};
            int_edge_i <= {12'h000, (k < 4) ? 2'(k) : 2'h3, 2'h0};
            for (int lv = 1; lv >= 0; lv--) begin
                @(posedge clk_i);
                ext_lvl[1] <= 1'(lv);
                note(7, 8'hFF, {6'h00, (k < 4) && ((lv == 1) ? k[0] : k[1]), 1'b0}, 3);
                note(8, 8'h01, {7'h00, (k < 4) && ((lv == 1) ? k[0] : k[1])}, 3);
                tick(4);
                int_clr_i <= 8'h02;
                note(7, 8'hFF, 8'h00, 1);
                note(8, 8'h01, 8'h00, 1);
                @(posedge clk_i);
                int_clr_i <= '0;
            end
        end
        // Hold keeps the driven state while the configuration changes
        mode_i <= {8{`GPC_DM_STRONG}};
        dout_wr_i <= 1'b1;
        dout_wdata_i <= 8'hFF;
        tick(3);
        dout_wr_i <= 1'b0;
        hold_i <= 1'b1;
        note(9, 8'h01, 8'h01, 1);
        @(posedge clk_i);
        mode_i <= '0;
        dout_wr_i <= 1'b1;
        dout_wdata_i <= 8'h00;
        for (int l = 1; l < 4; l++) begin
            note(0, 8'hFF, 8'h00, l);
            note(1, 8'hFF, 8'hFF, l);
        end
        tick(4);
        dout_wr_i <= 1'b0;
        hold_i <= 1'b0;
        note(9, 8'h01, 8'h00, 1);
        note(0, 8'hFF, 8'hFF, 2);
        tick(3);
        // Sleep without retention stays live
        sleep_i <= 1'b1;
        mode_i <= {8{`GPC_DM_STRONG}};
        note(9, 8'h01, 8'h00, 1);
        note(0, 8'hFF, 8'h00, 1);
        tick(2);
        // Sleep with retention holds, then a reset wake releases the pins
        retain_i <= 1'b1;
        note(9, 8'h01, 8'h01, 1);
        @(posedge clk_i);
        mode_i <= '0;
        note(0, 8'hFF, 8'h00, 2);
        tick(3);
        rst_i <= 1'b1;
        note(0, 8'hFF, 8'hFF, 1);
        note(9, 8'h01, 8'h00, 1);
        tick(2);
        rst_i <= 1'b0;
        sleep_i <= 1'b0;
        retain_i <= 1'b0;
        tick(3);
        end_of_test();
    end
endmodule : gpc_port_test
